// ### inc/dual_cc_pkg.sv
// package: register map, mode codes and field layout of the dual capture/compare block
package dual_cc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_VAL_ONE = 4'h1;
    localparam logic [3:0] ADDR_VAL_TWO = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h5;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int MODE_W = 4;
    localparam int SET_ONE_LSB = 0;
    localparam int SET_TWO_LSB = 4;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'ha;
    localparam logic [3:0] MODE_RESERVED = 4'hb;
    localparam logic [3:0] MODE_SPECIAL = 4'hf;
    localparam logic [3:0] PRESCALE_FOUR = 4'h3;
    localparam logic [3:0] PRESCALE_SIXTEEN = 4'hf;
    localparam int STAT_SET_ONE = 0;
    localparam int STAT_SET_TWO = 1;
    localparam int CTRL_ADC_EN = 0;
endpackage

// ### inc/cc_set_if.sv
// interface: one capture/compare set's mode, inputs and results
`timescale 1ns/1ps
`default_nettype none
interface cc_set_if;
    logic [3:0] mode;
    logic [15:0] compare_value;
    logic capture_rise;
    logic capture_fall;
    logic event_pulse;
    logic special_pulse;
    logic capture_load;
    logic pin_level;
    logic pin_owned;
    modport ctrl(output mode, output compare_value, output capture_rise,
        output capture_fall, input event_pulse, input special_pulse,
        input capture_load, input pin_level, input pin_owned);
    modport unit(input mode, input compare_value, input capture_rise,
        input capture_fall, output event_pulse, output special_pulse,
        output capture_load, output pin_level, output pin_owned);
endinterface
`default_nettype wire

// ### hdl/cc_set_unit.sv
// one capture/compare register set: mode decode, prescaler, match action
`timescale 1ns/1ps
`default_nettype none
module cc_set_unit (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [dual_cc_pkg::CNT_W-1:0] timer_one_count_i,
    cc_set_if.unit cc
);
    import dual_cc_pkg::*;

    typedef struct packed {
        logic [3:0] prescale;
        logic pin;
        logic match_d;
    } unit_s;

    unit_s state_reg;
    unit_s state_next;
    logic match;
    logic cap_mode;
    logic cmp_act;
    logic qualify;

    always_comb begin
        match = (timer_one_count_i == cc.compare_value);
        cap_mode = (cc.mode[3:2] == 2'b01);
        // reserved code behaves as idle
        cmp_act = cc.mode[3] && (cc.mode != MODE_RESERVED);
        state_next = state_reg;
        state_next.match_d = match;
        qualify = 1'b0;
        case (cc.mode)
            MODE_CAP_FALL: qualify = cc.capture_fall;
            MODE_CAP_RISE: qualify = cc.capture_rise;
            MODE_CAP_RISE4: qualify = cc.capture_rise &&
                (state_reg.prescale[1:0] == PRESCALE_FOUR[1:0]);
            MODE_CAP_RISE16: qualify = cc.capture_rise &&
                (state_reg.prescale == PRESCALE_SIXTEEN);
            default: qualify = 1'b0;
        endcase
        if (!cap_mode) begin
            state_next.prescale = '0;
        end else if (cc.capture_rise) begin
            state_next.prescale = state_reg.prescale + 4'h1;
        end
        // match acts once on entering equality, not every cycle it holds
        cc.event_pulse = qualify ||
            (cmp_act && match && !state_reg.match_d);
        cc.capture_load = qualify;
        cc.special_pulse = (cc.mode == MODE_SPECIAL) && match &&
            !state_reg.match_d;
        if (cc.mode[3:2] == 2'b00) begin
            state_next.pin = 1'b0;
        end else if (cc.mode == MODE_CMP_CLEAR && state_reg.pin == 1'b0
            && !(match && !state_reg.match_d)) begin
            state_next.pin = state_reg.pin;
        end
        if (match && !state_reg.match_d) begin
            case (cc.mode)
                MODE_CMP_SET: state_next.pin = 1'b1;
                MODE_CMP_CLEAR: state_next.pin = 1'b0;
                MODE_CMP_TOGGLE: state_next.pin = !state_reg.pin;
                default: state_next.pin = state_next.pin;
            endcase
        end
        // clear-on-match idles high, so its latch is stored inverted
        cc.pin_level = (cc.mode == MODE_CMP_CLEAR) ? !state_reg.pin
            : state_reg.pin;
        cc.pin_owned = (cc.mode == MODE_CMP_SET) ||
            (cc.mode == MODE_CMP_CLEAR) || (cc.mode == MODE_CMP_TOGGLE);
        if (cc.mode == MODE_CMP_CLEAR && match && !state_reg.match_d) begin
            state_next.pin = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// ### hdl/dual_capture_compare.sv
// top: dual capture/compare mode control with Avalon-MM registers
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dual_capture_compare #(
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [dual_cc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [dual_cc_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [dual_cc_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [CNT_W-1:0] timer_one_count_i,
    input wire logic capture_input_pin_i,
    output logic set_one_match_output_pin_o,
    output logic set_one_pin_owned_o,
    output logic set_two_match_output_pin_o,
    output logic set_two_pin_owned_o,
    output logic conversion_start_o,
    output logic irq_o
);
    import dual_cc_pkg::*;

    typedef struct packed {
        logic [7:0] dual_cc_mode_select_reg;
        logic [15:0] value_one;
        logic [15:0] value_two;
        logic [15:0] capt_one;
        logic [15:0] capt_two;
        logic [1:0] status;
        logic [1:0] mask;
        logic adc_en;
        logic pin_prev;
        logic busy;
        logic [31:0] rdata;
        logic pin_one;
        logic own_one;
        logic pin_two;
        logic own_two;
        logic conv;
        logic irq;
    } top_s;

    top_s state_reg;
    top_s state_next;
    logic [1:0] events;
    logic [1:0] w1c;
    logic wr_hit;
    logic rd_hit;
    logic wr_mode;
    logic wr_val_one;
    logic wr_val_two;
    logic wr_status;
    logic wr_mask;
    logic wr_ctrl;
    logic lane_lo;
    logic lane_hi;
    logic [DATA_W-1:0] read_word;

    cc_set_if set_one ();
    cc_set_if set_two ();

    ////////////////////////////////////////////////////////////////////
    assign set_one.mode = state_reg.dual_cc_mode_select_reg[
        SET_ONE_LSB +: MODE_W];
    assign set_two.mode = state_reg.dual_cc_mode_select_reg[
        SET_TWO_LSB +: MODE_W];
    assign set_one.compare_value = state_reg.value_one;
    assign set_two.compare_value = state_reg.value_two;
    assign set_one.capture_rise = capture_input_pin_i && !state_reg.pin_prev;
    assign set_one.capture_fall = !capture_input_pin_i && state_reg.pin_prev;
    assign set_two.capture_rise = set_one.capture_rise;
    assign set_two.capture_fall = set_one.capture_fall;

    cc_set_unit unit_one (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .timer_one_count_i(timer_one_count_i),
        .cc(set_one)
    );

    cc_set_unit unit_two (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .timer_one_count_i(timer_one_count_i),
        .cc(set_two)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] merge_byte(input logic [7:0] old,
        input logic [7:0] nw, input logic en);
        merge_byte = en ? nw : old;
    endfunction

    // one decode serves both the write strobes and the read mux
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] r);
        addr_is = (a == r);
    endfunction

    always_comb begin
        state_next = state_reg;
        events = {set_two.event_pulse, set_one.event_pulse};
        w1c = 2'b00;
        read_word = '0;
        lane_lo = avs_byteenable_i[0];
        lane_hi = avs_byteenable_i[1];

        // one wait cycle per access so readdata is a flop
        rd_hit = avs_read_i && !state_reg.busy;
        // a write lands on the edge where the master sees waitrequest low
        wr_hit = avs_write_i && state_reg.busy;
        state_next.busy = (avs_read_i || avs_write_i) && !state_reg.busy;
        state_next.pin_prev = capture_input_pin_i;

        // write strobes, one per word
        wr_mode = wr_hit && addr_is(avs_address_i, ADDR_MODE);
        wr_val_one = wr_hit && addr_is(avs_address_i, ADDR_VAL_ONE);
        wr_val_two = wr_hit && addr_is(avs_address_i, ADDR_VAL_TWO);
        wr_status = wr_hit && addr_is(avs_address_i, ADDR_STATUS);
        wr_mask = wr_hit && addr_is(avs_address_i, ADDR_MASK);
        wr_ctrl = wr_hit && addr_is(avs_address_i, ADDR_CTRL);

        // mode register
        if (wr_mode) begin
            state_next.dual_cc_mode_select_reg = merge_byte(
                state_reg.dual_cc_mode_select_reg,
                avs_writedata_i[7:0], lane_lo);
        end

        // compare values, two byte lanes each
        if (wr_val_one) begin
            state_next.value_one[7:0] = merge_byte(
                state_reg.value_one[7:0], avs_writedata_i[7:0],
                lane_lo);
            state_next.value_one[15:8] = merge_byte(
                state_reg.value_one[15:8], avs_writedata_i[15:8],
                lane_hi);
        end
        if (wr_val_two) begin
            state_next.value_two[7:0] = merge_byte(
                state_reg.value_two[7:0], avs_writedata_i[7:0],
                lane_lo);
            state_next.value_two[15:8] = merge_byte(
                state_reg.value_two[15:8], avs_writedata_i[15:8],
                lane_hi);
        end

        // status bits clear by writing one
        if (wr_status) begin
            w1c = avs_writedata_i[1:0] & {2{lane_lo}};
        end

        // interrupt mask
        if (wr_mask && lane_lo) begin
            state_next.mask = avs_writedata_i[1:0];
        end

        // converter enable
        if (wr_ctrl && lane_lo) begin
            state_next.adc_en = avs_writedata_i[CTRL_ADC_EN];
        end

        // a new event in the clearing cycle wins over the clear
        state_next.status = (state_reg.status & ~w1c) | events;

        // capture registers; an unread value is simply overwritten
        if (set_one.capture_load) begin
            state_next.capt_one = timer_one_count_i;
        end
        if (set_two.capture_load) begin
            state_next.capt_two = timer_one_count_i;
        end

        // read mux; unmapped words read as zero
        if (addr_is(avs_address_i, ADDR_MODE)) begin
            read_word[7:0] = state_reg.dual_cc_mode_select_reg;
        end
        if (addr_is(avs_address_i, ADDR_VAL_ONE)) begin
            read_word = {state_reg.capt_one, state_reg.value_one};
        end
        if (addr_is(avs_address_i, ADDR_VAL_TWO)) begin
            read_word = {state_reg.capt_two, state_reg.value_two};
        end
        if (addr_is(avs_address_i, ADDR_STATUS)) begin
            read_word[1:0] = state_reg.status;
        end
        if (addr_is(avs_address_i, ADDR_MASK)) begin
            read_word[1:0] = state_reg.mask;
        end
        if (addr_is(avs_address_i, ADDR_CTRL)) begin
            read_word[CTRL_ADC_EN] = state_reg.adc_en;
        end
        // readdata is zero outside the answering cycle
        state_next.rdata = rd_hit ? read_word : '0;

        // pin latches and ownership, registered for clean outputs
        state_next.pin_one = set_one.pin_level;
        state_next.own_one = set_one.pin_owned;
        state_next.pin_two = set_two.pin_level;
        state_next.own_two = set_two.pin_owned;

        // conversion start only; no timer clear output exists
        state_next.conv = state_reg.adc_en &&
            (set_one.special_pulse || set_two.special_pulse);

        // level interrupt from status and mask as they will stand
        state_next.irq = |(state_next.status & state_next.mask);
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.dual_cc_mode_select_reg <= MODE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign avs_readdata_o = state_reg.rdata;
    assign avs_waitrequest_o = !state_reg.busy;
    assign set_one_match_output_pin_o = state_reg.pin_one;
    assign set_one_pin_owned_o = state_reg.own_one;
    assign set_two_match_output_pin_o = state_reg.pin_two;
    assign set_two_pin_owned_o = state_reg.own_two;
    assign conversion_start_o = state_reg.conv;
    assign irq_o = state_reg.irq;
endmodule
`default_nettype wire

// ### verification/dual_cc_asserts.sv
// checker: bus timing, pin ownership and event outputs of the top
`timescale 1ns/1ps
`default_nettype none
module dual_cc_asserts import dual_cc_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [dual_cc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [dual_cc_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [dual_cc_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [CNT_W-1:0] timer_one_count_i,
    input wire logic capture_input_pin_i,
    input wire logic set_one_match_output_pin_o,
    input wire logic set_one_pin_owned_o,
    input wire logic set_two_match_output_pin_o,
    input wire logic set_two_pin_owned_o,
    input wire logic conversion_start_o,
    input wire logic irq_o
);
    logic [7:0] mode_reg;
    logic [1:0] mask_reg;
    logic adc_reg;
    // shadows follow the write that the slave accepts, not the request
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            mode_reg <= MODE_RESET;
            mask_reg <= 2'h0;
            adc_reg <= 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o) begin
            if (avs_address_i == ADDR_MODE)
                mode_reg <= avs_writedata_i[7:0];
            if (avs_address_i == ADDR_MASK)
                mask_reg <= avs_writedata_i[1:0];
            if (avs_address_i == ADDR_CTRL)
                adc_reg <= avs_writedata_i[CTRL_ADC_EN];
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////
    AST_WAIT_ANSWER: assert property ($rose(avs_read_i || avs_write_i)
        |=> !avs_waitrequest_o) else $error("no answer after request");
    AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_RDATA_IDLE: assert property (avs_waitrequest_o |-> avs_readdata_o
        == 32'h0) else $error("readdata not zero when idle");
    AST_OFF_FREE: assert property ((mode_reg[3:2] == 2'b00) [*3]
        |-> !set_one_pin_owned_o) else $error("off set still owns pin");
    AST_CMP_OWN: assert property ((mode_reg[3:2] == 2'b10 &&
        mode_reg[1:0] != 2'b11) [*3] |-> set_one_pin_owned_o)
        else $error("compare set does not own pin");
    AST_PORT_IO: assert property ((mode_reg[7:6] == 2'b11) [*3]
        |-> !set_two_pin_owned_o) else $error("pin not left as port");
    AST_RESV_IDLE: assert property ((mode_reg[7:4] == MODE_RESERVED)
        [*3] |-> !set_two_pin_owned_o && !$rose(set_two_match_output_pin_o))
        else $error("reserved mode acts");
    AST_SET_HOLD: assert property ((mode_reg[3:0] == MODE_CMP_SET) [*4]
        |-> !$fell(set_one_match_output_pin_o)) else $error("set output fell");
    AST_CLR_HOLD: assert property ((mode_reg[3:0] == MODE_CMP_CLEAR) [*5]
        |-> !$rose(set_one_match_output_pin_o)) else $error("clear out rose");
    AST_CONV_CAUSE: assert property (conversion_start_o |-> adc_reg &&
        (mode_reg[3:0] == MODE_SPECIAL || mode_reg[7:4] == MODE_SPECIAL))
        else $error("conversion start without cause");
    AST_CONV_PULSE: assert property (conversion_start_o
        |=> !conversion_start_o) else $error("conversion start too long");
    AST_IRQ_MASK: assert property ((mask_reg == 2'b00) [*2] |-> !irq_o)
        else $error("irq while fully masked");
endmodule
bind dual_capture_compare dual_cc_asserts #(.CNT_W(CNT_W)) u_asserts (
    .clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .timer_one_count_i(timer_one_count_i),
    .capture_input_pin_i(capture_input_pin_i),
    .set_one_match_output_pin_o(set_one_match_output_pin_o),
    .set_one_pin_owned_o(set_one_pin_owned_o),
    .set_two_match_output_pin_o(set_two_match_output_pin_o),
    .set_two_pin_owned_o(set_two_pin_owned_o),
    .conversion_start_o(conversion_start_o), .irq_o(irq_o));
`default_nettype wire

// ### verification/timer_pin_model.sv
// model: timer one counter and capture pin at the block's far side
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    input wire logic pin_req_i,
    output logic [15:0] timer_one_count_o,
    output logic capture_input_pin_o
);
    // a frozen count lets the bench know exactly what a capture must see
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            timer_one_count_o <= 16'h0000;
            capture_input_pin_o <= 1'b0;
        end else begin
            if (load_i)
                timer_one_count_o <= load_val_i;
            else if (run_i)
                timer_one_count_o <= timer_one_count_o + 16'h0001;
            capture_input_pin_o <= pin_req_i;
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// testbench: registers, capture, compare and event modes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
    import dual_cc_pkg::*;
    logic clock_i, resetn_i = 1'b0, rd = 1'b0, wr = 1'b0, wq, irq, conv;
    logic run = 1'b0, load = 1'b0, preq = 1'b0, tpin, p1, o1, p2, o2;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, rq, rdata;
    logic [15:0] lval = 16'h0, tcnt;
    int fail_count = 0, checks = 0, conv_n = 0;
    dual_capture_compare u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rq),
        .avs_waitrequest_o(wq), .timer_one_count_i(tcnt),
        .capture_input_pin_i(tpin), .set_one_match_output_pin_o(o1),
        .set_one_pin_owned_o(p1), .set_two_match_output_pin_o(o2),
        .set_two_pin_owned_o(p2), .conversion_start_o(conv), .irq_o(irq));
    timer_pin_model u_far (.clock_i(clock_i), .resetn_i(resetn_i),
        .run_i(run), .load_i(load), .load_val_i(lval), .pin_req_i(preq),
        .timer_one_count_o(tcnt), .capture_input_pin_o(tpin));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (conv === 1'b1) conv_n++;
    ////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        // no limit here: only the watchdog ends a wait with no answer
        do begin
            @(posedge clock_i);
        end while (wq !== 1'b0);
        rdata = rq;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic tset(input logic [15:0] v);
        @(posedge clock_i);
        load <= 1'b1;
        lval <= v;
        @(posedge clock_i);
        load <= 1'b0;
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock_i) preq <= 1'b1;
            repeat (3) @(posedge clock_i);
            preq <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask
    task automatic t_regs;
        bus(0, ADDR_MODE, 0);
        `CHK(rdata, 32'h0, "mode reset")
        bus(1, ADDR_MODE, 32'ha5);
        bus(0, ADDR_MODE, 0);
        `CHK(rdata[7:0], 8'ha5, "mode readback")
        bus(1, 4'h9, 32'hff);
        bus(0, 4'h9, 0);
        `CHK(rdata, 32'h0, "unmapped read")
    endtask
    task automatic t_capture;
        logic [3:0] md[4];
        int nn[4];
        md = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
        nn = '{1, 1, 4, 16};
        for (int i = 0; i < 4; i++) begin
            bus(1, ADDR_MODE, 0);
            tset(16'(16'h1230 + i));
            bus(1, ADDR_MODE, {28'h0, md[i]});
            bus(1, ADDR_STATUS, 3);
            pulses(nn[i] - 1);
            bus(0, ADDR_STATUS, 0);
            `CHK(rdata[0], 1'b0, "early capture")
            pulses(1);
            bus(0, ADDR_STATUS, 0);
            `CHK(rdata[0], 1'b1, "capture flag")
            bus(0, ADDR_VAL_ONE, 0);
            `CHK(rdata[31:16], 16'(16'h1230 + i), "capture value")
        end
        tset(16'h5555);
        bus(1, ADDR_MODE, {28'h0, MODE_CAP_RISE});
        pulses(1);
        tset(16'h6666);
        pulses(1);
        bus(0, ADDR_VAL_ONE, 0);
        `CHK(rdata[31:16], 16'h6666, "overwrite")
    endtask
    task automatic t_compare;
        logic [3:0] cm[3];
        logic pre[3];
        logic post[3];
        cm = '{MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_TOGGLE};
        pre = '{1'b0, 1'b1, 1'b0};
        post = '{1'b1, 1'b0, 1'b1};
        run <= 1'b1;
        bus(1, ADDR_VAL_ONE, 32'h0100);
        bus(1, ADDR_VAL_TWO, 32'h0100);
        for (int i = 0; i < 3; i++) begin
            bus(1, ADDR_MODE, 0);
            bus(1, ADDR_MODE, {24'h0, cm[i], cm[i]});
            bus(1, ADDR_STATUS, 3);
            tset(16'h00f0);
            repeat (3) @(posedge clock_i);
            `CHK({o2, o1}, {pre[i], pre[i]}, "before match")
            repeat (30) @(posedge clock_i);
            `CHK({o2, o1}, {post[i], post[i]}, "after match")
            `CHK({p2, p1}, 2'b11, "pins owned")
            `CHK(tcnt > 16'h0100, 1'b1, "timer kept")
            bus(0, ADDR_STATUS, 0);
            `CHK(rdata[1:0], 2'b11, "match flags")
        end
        bus(1, ADDR_MODE, 0);
        repeat (3) @(posedge clock_i);
        `CHK({o2, o1}, 2'b00, "off default")
        `CHK({p2, p1}, 2'b00, "off releases pin")
    endtask
    task automatic t_event;
        bus(1, ADDR_VAL_TWO, 32'h0100);
        bus(1, ADDR_CTRL, 1);
        bus(1, ADDR_MODE, {24'h0, MODE_SPECIAL, 4'hc});
        bus(1, ADDR_STATUS, 3);
        conv_n = 0;
        tset(16'h00f0);
        repeat (30) @(posedge clock_i);
        `CHK(conv_n, 1, "one conversion")
        `CHK({p2, p1}, 2'b00, "pins as port")
        `CHK(tcnt > 16'h0100, 1'b1, "timer kept")
        bus(0, ADDR_STATUS, 0);
        `CHK(rdata[1:0], 2'b11, "both flags")
        bus(1, ADDR_MASK, 2);
        repeat (3) @(posedge clock_i);
        `CHK(irq, 1'b1, "irq raised")
        bus(1, ADDR_STATUS, 2);
        repeat (3) @(posedge clock_i);
        `CHK(irq, 1'b0, "irq cleared")
        bus(1, ADDR_MODE, {24'h0, MODE_RESERVED, MODE_SPECIAL});
        bus(1, ADDR_STATUS, 3);
        conv_n = 0;
        tset(16'h00f0);
        repeat (30) @(posedge clock_i);
        bus(0, ADDR_STATUS, 0);
        `CHK(rdata[1:0], 2'b01, "special one, reserved two")
        `CHK(conv_n, 1, "conversion by set one")
        bus(1, ADDR_CTRL, 0);
        conv_n = 0;
        tset(16'h00f0);
        repeat (30) @(posedge clock_i);
        `CHK(conv_n, 0, "converter disabled")
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_regs();
        t_capture();
        t_compare();
        t_event();
        print_verdict();
    end
    // generous bound: the whole sequence needs well under 10000 cycles
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
